// >>> logic/address_clock_data_pin_mux.sv
/*
 Pin multiplexer for the four upper port B pins (general-purpose,
 upper address lines or clock monitors) and the seven shared port F pins
 (low data lines or general-purpose), with its configuration registers.
 Assumes the memory interface supplies address, data and an activity
 flag on ref_clk, and that pads resolve level from out and enable.
*/
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
module address_clock_data_pin_mux
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic                             ref_clk,
   input  wire logic                             reset_n,
   // register port
   input  wire logic [ADDR_W-1:0]                reg_addr,
   input  wire logic [pin_mux_pkg::REG_W-1:0]    reg_wr_data,
   input  wire logic                             reg_wr_en,
   input  wire logic                             reg_rd_en,
   output logic      [pin_mux_pkg::REG_W-1:0]    reg_rd_data,
   // memory interface side
   input  wire logic [pin_mux_pkg::PB_PINS-1:0]  upper_address_lines,
   input  wire logic [pin_mux_pkg::PF_PINS-1:0]  low_data_lines,
   input  wire logic                             ext_data_write,
   input  wire logic                             ext_bus_active,
   output logic      [pin_mux_pkg::PF_PINS-1:0]  low_data_in,
   output logic                                  ext_ctrl_oe,
   // clocks offered for monitoring
   input  wire logic                             prescaler_clock,
   input  wire logic                             system_clock_primary,
   input  wire logic                             system_clock_secondary,
   input  wire logic                             oscillator_clock,
   // upper port B pads
   input  wire logic [pin_mux_pkg::PB_PINS-1:0]  pb_pin_in,
   output logic      [pin_mux_pkg::PB_PINS-1:0]  pb_pin_out,
   output logic      [pin_mux_pkg::PB_PINS-1:0]  pb_pin_oe,
   output logic      [pin_mux_pkg::PB_PINS-1:0]  pb_pullup_on,
   // shared port F pads
   input  wire logic [pin_mux_pkg::PF_PINS-1:0]  pf_pin_in,
   output logic      [pin_mux_pkg::PF_PINS-1:0]  pf_pin_out,
   output logic      [pin_mux_pkg::PF_PINS-1:0]  pf_pin_oe,
   output logic      [pin_mux_pkg::PF_PINS-1:0]  pf_pullup_on
);
   import pin_mux_pkg::*;

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   if (ADDR_W < 4 || ADDR_W > 8)
   begin : g_bad_addr_w
      $error("ADDR_W must lie between 4 and 8");
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [PB_PINS-1:0]  pb_data_ff,    nxt_pb_data;
   logic [PB_PINS-1:0]  pb_dir_ff,     nxt_pb_dir;
   logic [PB_PINS-1:0]  pb_periph_ff,  nxt_pb_periph;
   logic [PB_PINS-1:0]  pb_pullup_ff,  nxt_pb_pullup;
   logic [PB_PINS-1:0]  clk_sel_ff,    nxt_clk_sel;
   logic [PF_PINS-1:0]  pf_data_ff,    nxt_pf_data;
   logic [PF_PINS-1:0]  pf_dir_ff,     nxt_pf_dir;
   logic [PF_PINS-1:0]  pf_periph_ff,  nxt_pf_periph;
   logic [PF_PINS-1:0]  pf_pullup_ff,  nxt_pf_pullup;
   logic                drive_sel_ff,  nxt_drive_sel;
   logic [REG_W-1:0]    rd_data_ff,    nxt_rd_data;
   logic [PB_PINS-1:0]  pb_meta_ff,    pb_sync_ff;
   logic [PF_PINS-1:0]  pf_meta_ff,    pf_sync_ff;
   logic [7:0]          idx;
   logic [PB_PINS-1:0]  clk_src;
   logic                bus_drive;

   // short addresses are zero-extended so the index compare stays 8 bits
   assign idx = 8'(reg_addr);

   // write decode: one register per index, other bits ignored
   always_comb
   begin
      nxt_pb_data   = pb_data_ff;
      nxt_pb_dir    = pb_dir_ff;
      nxt_pb_periph = pb_periph_ff;
      nxt_pb_pullup = pb_pullup_ff;
      nxt_clk_sel   = clk_sel_ff;
      nxt_pf_data   = pf_data_ff;
      nxt_pf_dir    = pf_dir_ff;
      nxt_pf_periph = pf_periph_ff;
      nxt_pf_pullup = pf_pullup_ff;
      nxt_drive_sel = drive_sel_ff;
      if (reg_wr_en)
      begin
         case (idx)
            IDX_PB_DATA:   nxt_pb_data   = reg_wr_data[PB_PINS-1:0];
            IDX_PB_DIR:    nxt_pb_dir    = reg_wr_data[PB_PINS-1:0];
            IDX_PB_PERIPH: nxt_pb_periph = reg_wr_data[PB_PINS-1:0];
            IDX_PB_PULLUP: nxt_pb_pullup = reg_wr_data[PB_PINS-1:0];
            IDX_CLK_SEL:   nxt_clk_sel   = reg_wr_data[PB_PINS-1:0];
            IDX_PF_DATA:   nxt_pf_data   = reg_wr_data[PF_MSB:PF_LSB];
            IDX_PF_DIR:    nxt_pf_dir    = reg_wr_data[PF_MSB:PF_LSB];
            IDX_PF_PERIPH: nxt_pf_periph = reg_wr_data[PF_MSB:PF_LSB];
            IDX_PF_PULLUP: nxt_pf_pullup = reg_wr_data[PF_MSB:PF_LSB];
            IDX_BUS_CTRL:  nxt_drive_sel = reg_wr_data[DRIVE_SEL_BIT];
            default:       nxt_drive_sel = drive_sel_ff;
         endcase
      end
   end

   // read mux: data appear in the cycle after the strobe only
   always_comb
   begin
      nxt_rd_data = '0;
      if (reg_rd_en)
      begin
         case (idx)
            IDX_PB_DATA:   nxt_rd_data[PB_PINS-1:0] = pb_data_ff;
            IDX_PB_DIR:    nxt_rd_data[PB_PINS-1:0] = pb_dir_ff;
            IDX_PB_PERIPH: nxt_rd_data[PB_PINS-1:0] = pb_periph_ff;
            IDX_PB_PULLUP: nxt_rd_data[PB_PINS-1:0] = pb_pullup_ff;
            IDX_PB_IN:     nxt_rd_data[PB_PINS-1:0] = pb_sync_ff;
            IDX_CLK_SEL:   nxt_rd_data[PB_PINS-1:0] = clk_sel_ff;
            IDX_PF_DATA:   nxt_rd_data[PF_MSB:PF_LSB] = pf_data_ff;
            IDX_PF_DIR:    nxt_rd_data[PF_MSB:PF_LSB] = pf_dir_ff;
            IDX_PF_PERIPH: nxt_rd_data[PF_MSB:PF_LSB] = pf_periph_ff;
            IDX_PF_PULLUP: nxt_rd_data[PF_MSB:PF_LSB] = pf_pullup_ff;
            IDX_PF_IN:     nxt_rd_data[PF_MSB:PF_LSB] = pf_sync_ff;
            IDX_BUS_CTRL:  nxt_rd_data[DRIVE_SEL_BIT] = drive_sel_ff;
            default:       nxt_rd_data = '0;
         endcase
      end
   end

   // configuration and read-back registers
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pb_data_ff   <= RST_PB_DATA;
         pb_dir_ff    <= RST_PB_DIR;
         pb_periph_ff <= RST_PB_PERIPH;
         pb_pullup_ff <= RST_PB_PULLUP;
         clk_sel_ff   <= RST_CLK_SEL;
         pf_data_ff   <= RST_PF_DATA;
         pf_dir_ff    <= RST_PF_DIR;
         pf_periph_ff <= RST_PF_PERIPH;
         pf_pullup_ff <= RST_PF_PULLUP;
         drive_sel_ff <= RST_DRIVE_SEL;
         rd_data_ff   <= '0;
      end
      else
      begin
         pb_data_ff   <= nxt_pb_data;
         pb_dir_ff    <= nxt_pb_dir;
         pb_periph_ff <= nxt_pb_periph;
         pb_pullup_ff <= nxt_pb_pullup;
         clk_sel_ff   <= nxt_clk_sel;
         pf_data_ff   <= nxt_pf_data;
         pf_dir_ff    <= nxt_pf_dir;
         pf_periph_ff <= nxt_pf_periph;
         pf_pullup_ff <= nxt_pf_pullup;
         drive_sel_ff <= nxt_drive_sel;
         rd_data_ff   <= nxt_rd_data;
      end
   end

   assign reg_rd_data = rd_data_ff;

   // ------------------------------------------------------------------
   // pad input synchronisers
   // ------------------------------------------------------------------
   // pads are asynchronous to ref_clk; the first stage feeds only the second
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pb_meta_ff <= '0;
         pb_sync_ff <= '0;
         pf_meta_ff <= '0;
         pf_sync_ff <= '0;
      end
      else
      begin
         pb_meta_ff <= pb_pin_in;
         pb_sync_ff <= pb_meta_ff;
         pf_meta_ff <= pf_pin_in;
         pf_sync_ff <= pf_meta_ff;
      end
   end

   // read data seen by the memory interface costs two cycles of latency
   assign low_data_in = pf_sync_ff;

   // ------------------------------------------------------------------
   // pad multiplexers
   // ------------------------------------------------------------------
   // lines are held driven while idle only when drive select is set
   assign bus_drive   = ext_bus_active | drive_sel_ff;
   assign ext_ctrl_oe = bus_drive;

   // monitor clocks pass without flops; registering would alias them
   assign clk_src = {oscillator_clock, system_clock_secondary,
                     system_clock_primary, prescaler_clock};

   // one pin per iteration; general-purpose wins while periph bit clear
   for (genvar i = 0; i < PB_PINS; i++)
   begin : g_pb
      always_comb
      begin
         if (!pb_periph_ff[i])
         begin
            pb_pin_out[i] = pb_data_ff[i];
            pb_pin_oe[i]  = pb_dir_ff[i];
         end
         else if (clk_sel_ff[i])
         begin
            pb_pin_out[i] = clk_src[i];
            pb_pin_oe[i]  = 1'b1;
         end
         else
         begin
            pb_pin_out[i] = upper_address_lines[i];
            pb_pin_oe[i]  = bus_drive;
         end
      end
      assign pb_pullup_on[i] = pb_pullup_ff[i];
   end

   // data lines drive on writes; an idle bus floats them unless held
   for (genvar j = 0; j < PF_PINS; j++)
   begin : g_pf
      always_comb
      begin
         if (pf_periph_ff[j])
         begin
            pf_pin_out[j] = low_data_lines[j];
            pf_pin_oe[j]  = ext_bus_active ? ext_data_write
                                           : drive_sel_ff;
         end
         else
         begin
            pf_pin_out[j] = pf_data_ff[j];
            pf_pin_oe[j]  = pf_dir_ff[j];
         end
      end
      assign pf_pullup_on[j] = pf_pullup_ff[j];
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_gpio_b_dir;
      ((pb_pin_oe ^ pb_dir_ff) & ~pb_periph_ff) == '0;
   endproperty
   a_gpio_b_dir: assert property (p_gpio_b_dir)
      else $error("gpio pin b enable not following direction");

   property p_addr_out;
      ((pb_pin_out ^ upper_address_lines) & pb_periph_ff & ~clk_sel_ff)
         == '0;
   endproperty
   a_addr_out: assert property (p_addr_out)
      else $error("address pin not carrying address");

   property p_addr_float;
      (!ext_bus_active && !drive_sel_ff)
         |-> ((pb_pin_oe & pb_periph_ff & ~clk_sel_ff) == '0)
             && !ext_ctrl_oe;
   endproperty
   a_addr_float: assert property (p_addr_float)
      else $error("address lines driven while bus idle");

   property p_clk_out;
      ((pb_pin_out ^ clk_src) & pb_periph_ff & clk_sel_ff) == '0;
   endproperty
   a_clk_out: assert property (p_clk_out)
      else $error("clock pin not carrying its clock");

   property p_periph_write;
      (reg_wr_en && idx == IDX_PB_PERIPH)
         |=> pb_periph_ff == $past(reg_wr_data[PB_PINS-1:0]);
   endproperty
   a_periph_write: assert property (p_periph_write)
      else $error("port b peripheral enable not updated");

   property p_data_float;
      (!ext_bus_active && !drive_sel_ff) |-> (pf_pin_oe & pf_periph_ff) == '0;
   endproperty
   a_data_float: assert property (p_data_float)
      else $error("data lines driven while bus idle");

   property p_data_out;
      ((pf_pin_out ^ low_data_lines) & pf_periph_ff) == '0;
   endproperty
   a_data_out: assert property (p_data_out)
      else $error("data pin not carrying data");

   property p_pf_in_read;
      (reg_rd_en && idx == IDX_PF_IN)
         |=> reg_rd_data[PF_MSB:PF_LSB] == $past(pf_sync_ff)
             ##1 reg_rd_data == '0 || $past(reg_rd_en);
   endproperty
   a_pf_in_read: assert property (p_pf_in_read)
      else $error("port f input read-back wrong");

   property p_pullup;
      (reg_wr_en && idx == IDX_PF_PULLUP)
         |=> pf_pullup_on == $past(reg_wr_data[PF_MSB:PF_LSB]);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("port f pull-up not following register");

   property p_reset_state;
      $rose(reset_n) |-> pb_periph_ff == '0 && pf_periph_ff == '1;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("pin function wrong after reset");

endmodule : address_clock_data_pin_mux

// >>> logic/pin_mux_pkg.sv
/*
 Constants for the address, clock and data pin multiplexer: register
 indices, field positions, reset values and pin counts.
 Assumes one 16-bit register word per index on the plain register port.
*/
package pin_mux_pkg;

   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int          REG_W      = 16;
   localparam int          PB_PINS    = 4;
   localparam int          PF_PINS    = 7;
   localparam int          PF_LSB     = 9;   // port F bit of the first pin
   localparam int          PF_MSB     = 15;

   // ------------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------------
   localparam logic [7:0]  IDX_PB_DATA   = 8'h00;
   localparam logic [7:0]  IDX_PB_DIR    = 8'h01;
   localparam logic [7:0]  IDX_PB_PERIPH = 8'h02;
   localparam logic [7:0]  IDX_PB_PULLUP = 8'h03;
   localparam logic [7:0]  IDX_PB_IN     = 8'h04;
   localparam logic [7:0]  IDX_CLK_SEL   = 8'h05;
   localparam logic [7:0]  IDX_PF_DATA   = 8'h06;
   localparam logic [7:0]  IDX_PF_DIR    = 8'h07;
   localparam logic [7:0]  IDX_PF_PERIPH = 8'h08;
   localparam logic [7:0]  IDX_PF_PULLUP = 8'h09;
   localparam logic [7:0]  IDX_PF_IN     = 8'h0a;
   localparam logic [7:0]  IDX_BUS_CTRL  = 8'h0b;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int          DRIVE_SEL_BIT  = 0;
   localparam logic [3:0]  RST_PB_DATA    = 4'h0;
   localparam logic [3:0]  RST_PB_DIR     = 4'h0;
   localparam logic [3:0]  RST_PB_PERIPH  = 4'h0;
   localparam logic [3:0]  RST_PB_PULLUP  = 4'hf;
   localparam logic [3:0]  RST_CLK_SEL    = 4'h0;
   localparam logic [6:0]  RST_PF_DATA    = 7'h00;
   localparam logic [6:0]  RST_PF_DIR     = 7'h00;
   localparam logic [6:0]  RST_PF_PERIPH  = 7'h7f;
   localparam logic [6:0]  RST_PF_PULLUP  = 7'h7f;
   localparam logic        RST_DRIVE_SEL  = 1'b0;

endpackage : pin_mux_pkg

// >>> tb/ext_mem_model.sv
/*
 Behavioural external memory and pad model for the pin multiplexer bench.
 Assumes the bench says when the memory answers a read on the data lines;
 undriven lines follow the pull-up, or else invert their last value.
*/
`timescale 1ns/100ps
module ext_mem_model
(
   input  wire logic       ref_clk,
   input  wire logic       mem_drive,
   input  wire logic [6:0] mem_data,
   input  wire logic [6:0] pf_out,
   input  wire logic [6:0] pf_oe,
   input  wire logic [6:0] pf_pu,
   input  wire logic [3:0] pb_out,
   input  wire logic [3:0] pb_oe,
   input  wire logic [3:0] pb_pu,
   output logic      [6:0] pf_in,
   output logic      [3:0] pb_in
);
   // ------------------------------------------------------------------
   // wire resolution
   // ------------------------------------------------------------------
   logic [6:0] pf_last = 7'h00;
   logic [3:0] pb_last = 4'h0;

   // a floating line must not look like a held value, so it toggles
   always_ff @(posedge ref_clk)
   begin
      pf_last <= pf_in;
      pb_last <= pb_in;
   end

   // device drive wins, then the memory's read answer, then the pull-up
   always_comb
   begin
      for (int i = 0; i < 7; i++)
      begin
         pf_in[i] = pf_oe[i] ? pf_out[i] : mem_drive ? mem_data[i] :
                    pf_pu[i] ? 1'b1 : ~pf_last[i];
      end
      for (int i = 0; i < 4; i++)
      begin
         pb_in[i] = pb_oe[i] ? pb_out[i] : pb_pu[i] ? 1'b1 : ~pb_last[i];
      end
   end
endmodule : ext_mem_model

// >>> tb/tb_address_clock_data_pin_mux.sv
/*
 Self-checking bench for the pin multiplexer: reset values, table of pad
 configurations, then data input path, pull-up control, unmapped access and reset again.
 Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
module tb_address_clock_data_pin_mux;
   import pin_mux_pkg::*;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] pbper, clks, pbdir, pbdat;
      logic [6:0] pfper, pfdir, pfdat;
      logic       dsel, act, wr;
      logic [3:0] e_pbo, e_pboe;
      logic [6:0] e_pfo, e_pfoe;
      logic       e_ctl;
   } row_s;
   logic              ref_clk, reset_n, reg_wr_en, reg_rd_en;
   logic [7:0]        reg_addr;
   logic [REG_W-1:0]  reg_wr_data, reg_rd_data, rd_val;
   logic [3:0]        pb_in, pb_out, pb_oe, pb_pu, addr_lines, clocks;
   logic [6:0]        pf_in, pf_out, pf_oe, pf_pu, data_in, wdata, mdata;
   logic              wr_cyc, active, ctrl_oe, mem_drive;
   int                mismatches, num_checks;
   row_s              rows [8];

   address_clock_data_pin_mux address_clock_data_pin_mux_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .upper_address_lines(addr_lines), .low_data_lines(wdata),
      .ext_data_write(wr_cyc), .ext_bus_active(active),
      .low_data_in(data_in), .ext_ctrl_oe(ctrl_oe),
      .prescaler_clock(clocks[0]), .system_clock_primary(clocks[1]),
      .system_clock_secondary(clocks[2]), .oscillator_clock(clocks[3]),
      .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe),
      .pb_pullup_on(pb_pu), .pf_pin_in(pf_in), .pf_pin_out(pf_out),
      .pf_pin_oe(pf_oe), .pf_pullup_on(pf_pu));

   ext_mem_model ext_mem_model_i (
      .ref_clk(ref_clk), .mem_drive(mem_drive), .mem_data(mdata),
      .pf_out(pf_out), .pf_oe(pf_oe), .pf_pu(pf_pu), .pb_out(pb_out),
      .pb_oe(pb_oe), .pb_pu(pb_pu), .pf_in(pf_in), .pb_in(pb_in));

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic check(string name, logic [15:0] got, logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic write_reg(logic [7:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
   endtask : write_reg

   // strobe seen at the second edge, data stands in the cycle after it
   task automatic read_reg(logic [7:0] a);
      @(posedge ref_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1;
      rd_val = reg_rd_data;
   endtask : read_reg

   task automatic do_reset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
   endtask : do_reset

   task automatic reset_checks(string name);
      #1;
      check("pb_pin_oe", {12'h000, pb_oe}, 16'h0000);
      check("pf_pin_oe", {9'h000, pf_oe}, 16'h0000);
      check("pf_pullup_on", {9'h000, pf_pu}, 16'h007f);
      check("pb_pullup_on", {12'h000, pb_pu}, 16'h000f);
      read_reg(IDX_PB_PERIPH);
      check("pb periph", rd_val, 16'h0000);
      read_reg(IDX_PF_PERIPH);
      check("pf periph", rd_val, 16'hfe00);
      read_reg(IDX_BUS_CTRL);
      check("bus ctrl", rd_val, 16'h0000);
      $display("test %s done", name);
   endtask : reset_checks

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   // ------------------------------------------------------------------
   // clock, watchdog and stimulus
   // ------------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // the sequence needs well under 2000 cycles
   initial
   begin
      #(4 * 20000);
      mismatches++;
      print_verdict();
   end

   // clock levels 1,0,1,0 make each monitor pin distinguishable
   initial
   begin
      row_s r;
      reset_n = 1'b0; reg_wr_en = 1'b0; reg_rd_en = 1'b0;
      reg_addr = 8'h00; reg_wr_data = 16'h0000; addr_lines = 4'ha;
      clocks = 4'h5; wdata = 7'h35; mdata = 7'h2b; wr_cyc = 1'b0;
      active = 1'b0; mem_drive = 1'b0; mismatches = 0; num_checks = 0;
      rows[0] = '{4'h0,4'h0,4'hf,4'h3,7'h7f,7'h00,7'h00,1'b0,1'b1,1'b1,
                  4'h3,4'hf,7'h35,7'h7f,1'b1};
      rows[1] = '{4'h0,4'h0,4'h5,4'hf,7'h7f,7'h00,7'h00,1'b0,1'b1,1'b0,
                  4'h5,4'h5,7'h00,7'h00,1'b1};
      rows[2] = '{4'hf,4'h0,4'h0,4'h0,7'h00,7'h7f,7'h4a,1'b0,1'b1,1'b0,
                  4'ha,4'hf,7'h4a,7'h7f,1'b1};
      rows[3] = '{4'hf,4'h0,4'h0,4'h0,7'h7f,7'h00,7'h00,1'b0,1'b0,1'b0,
                  4'h0,4'h0,7'h00,7'h00,1'b0};
      rows[4] = '{4'hf,4'h0,4'h0,4'h0,7'h7f,7'h00,7'h00,1'b1,1'b0,1'b0,
                  4'ha,4'hf,7'h35,7'h7f,1'b1};
      rows[5] = '{4'hf,4'hf,4'h0,4'h0,7'h0f,7'h70,7'h7f,1'b0,1'b1,1'b1,
                  4'h5,4'hf,7'h75,7'h7f,1'b1};
      rows[6] = '{4'h3,4'hf,4'hf,4'h0,7'h7f,7'h00,7'h00,1'b0,1'b1,1'b1,
                  4'h1,4'hf,7'h35,7'h7f,1'b1};
      rows[7] = '{4'hc,4'h4,4'h3,4'h2,7'h7f,7'h00,7'h00,1'b0,1'b1,1'b0,
                  4'he,4'hf,7'h00,7'h00,1'b1};
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      reset_checks("reset");
      for (int i = 0; i < 8; i++)
      begin
         r = rows[i];
         write_reg(IDX_PB_PERIPH, {12'h000, r.pbper});
         write_reg(IDX_CLK_SEL, {12'h000, r.clks});
         write_reg(IDX_PB_DIR, {12'h000, r.pbdir});
         write_reg(IDX_PB_DATA, {12'h000, r.pbdat});
         write_reg(IDX_PF_PERIPH, {r.pfper, 9'h000});
         write_reg(IDX_PF_DIR, {r.pfdir, 9'h000});
         write_reg(IDX_PF_DATA, {r.pfdat, 9'h000});
         write_reg(IDX_BUS_CTRL, {15'h0000, r.dsel});
         @(posedge ref_clk);
         active <= r.act;
         wr_cyc <= r.wr;
         @(posedge ref_clk);
         #1;
         check("pb_pin_oe", {12'h000, pb_oe}, {12'h000, r.e_pboe});
         check("pb_pin_out", {12'h000, pb_out & r.e_pboe},
               {12'h000, r.e_pbo});
         check("pf_pin_oe", {9'h000, pf_oe}, {9'h000, r.e_pfoe});
         check("pf_pin_out", {9'h000, pf_out & r.e_pfoe},
               {9'h000, r.e_pfo});
         check("ext_ctrl_oe", {15'h0000, ctrl_oe}, {15'h0000, r.e_ctl});
         $display("test row %0d done", i);
      end
      // memory answers a read on the data lines, seen after the syncs
      @(posedge ref_clk);
      mem_drive <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check("low_data_in", {9'h000, data_in}, 16'h002b);
      @(posedge ref_clk);
      mem_drive <= 1'b0;
      write_reg(IDX_PB_PERIPH, 16'h0000);
      write_reg(IDX_PB_DIR, 16'h0000);
      // the pull-up level needs both sync stages before it can be read
      repeat (2) @(posedge ref_clk);
      read_reg(IDX_PB_IN);
      check("pb input", rd_val, 16'h000f);
      $display("test data input done");
      write_reg(IDX_PF_PULLUP, 16'hfc00);
      #1;
      check("pf_pullup_on", {9'h000, pf_pu}, 16'h007e);
      read_reg(IDX_PF_PULLUP);
      check("pf pullup", rd_val, 16'hfc00);
      // nonzero read data must fall back to zero one cycle later
      @(posedge ref_clk);
      #1;
      check("rd after", reg_rd_data, 16'h0000);
      read_reg(8'h20);
      check("unmapped", rd_val, 16'h0000);
      $display("test pullup and unmapped done");
      write_reg(IDX_PB_PERIPH, 16'h000f);
      write_reg(IDX_BUS_CTRL, 16'h0001);
      active <= 1'b0;
      do_reset();
      reset_checks("second reset");
      print_verdict();
   end
endmodule : tb_address_clock_data_pin_mux
